// ===== src/tsp_tx_segment_end.v
// transmit segment end, error and empty-byte handling with output buffer
// What this block does
// - the end marker is looked at only when that segment's enable is high.
// - the error flag is looked at only when both enable and end marker are high.
// - a bad packet's last data word is replaced by the Ethernet error control word.
// - frame check handling is switched off for a bad packet only and resumes for the next.
// - each segment has a four-bit count of invalid bytes on the final transfer, which are trimmed.
// - the empty-byte count is looked at only when both enable and end marker are high.
// - with end and error both high the low three count bits are taken as zero, the top bit as given.
// - four independent segments, zero to three, each with its own end, error and count inputs.
// - a segment's 128-bit data is captured in every cycle its enable is high and the buffer has room; when full the word is dropped.
`timescale 1ns/10ps
`include "tsp_defines.vh"
module tsp_tx_segment_end #(
   parameter NUM_SEG = `TSP_NUM_SEG,
   parameter DATA_W  = `TSP_DATA_W,
   parameter EMPTY_W = `TSP_EMPTY_W
) (
   input  wire                   CLOCK,
   input  wire                   RST_B,
   input  wire [NUM_SEG-1:0]     SEG_VALID_ENABLE,
   input  wire [NUM_SEG-1:0]     SEG_START_MARKER,
   input  wire [NUM_SEG-1:0]     SEG_END_MARKER,
   input  wire [NUM_SEG-1:0]     SEG_BAD_PACKET_FLAG,
   input  wire [NUM_SEG*EMPTY_W-1:0] SEG_EMPTY_BYTE_COUNT,
   input  wire [NUM_SEG*DATA_W-1:0]  SEG_PAYLOAD_BUS,
   output reg                    SEG_READY,
   output reg                    SEG_OVERFLOW,
   output reg                    OUT_VALID,
   input  wire                   OUT_READY,
   output reg  [NUM_SEG-1:0]     OUT_SEG_VALID,
   output reg  [NUM_SEG-1:0]     OUT_SEG_START,
   output reg  [NUM_SEG-1:0]     OUT_SEG_END,
   output reg  [NUM_SEG-1:0]     OUT_SEG_ERROR,
   output reg  [NUM_SEG*5-1:0]   OUT_SEG_BYTE_COUNT,
   output reg  [NUM_SEG-1:0]     OUT_SEG_FCS_ENABLE,
   output reg  [NUM_SEG*DATA_W-1:0] OUT_SEG_DATA
);
   localparam SEG_W = DATA_W + 5 + 5;
   localparam BUF_W = NUM_SEG * SEG_W;

   wire [BUF_W-1:0] in_word;
   wire [BUF_W-1:0] buf_word;
   wire             buf_valid;
   wire             buf_in_ready;
   wire             take_out;
   wire             any_enable;

   assign any_enable = |SEG_VALID_ENABLE;
   assign take_out   = ~OUT_VALID | OUT_READY;

   // per segment qualification; bit order of segments sets byte order
   genvar g;
   generate
      for (g = 0; g < NUM_SEG; g = g + 1) begin : g_seg
         wire            ena;
         wire            sop;
         wire            eop;
         wire            err;
         wire [EMPTY_W-1:0] empty;
         wire [4:0]      bytes;
         wire [DATA_W-1:0] data;
         assign ena   = SEG_VALID_ENABLE[g];
         assign sop   = ena & SEG_START_MARKER[g];
         assign eop   = ena & SEG_END_MARKER[g];
         assign err   = eop & SEG_BAD_PACKET_FLAG[g];
         // empty count only used at the end; low bits forced to zero on error
         assign empty = ~eop ? {EMPTY_W{1'b0}} :
                        err  ? (SEG_EMPTY_BYTE_COUNT[g*EMPTY_W +: EMPTY_W] & `TSP_EMPTY_LOW_MASK) :
                               SEG_EMPTY_BYTE_COUNT[g*EMPTY_W +: EMPTY_W];
         // valid bytes left after trimming the empty ones
         assign bytes = ~ena ? 5'h00 : (`TSP_SEG_BYTES - {1'b0, empty});
         // bad packet: last word replaced by error control word
         assign data  = err ? `TSP_ERR_CODE_WORD : SEG_PAYLOAD_BUS[g*DATA_W +: DATA_W];
         // frame check stays on for enabled segments, off only where a bad packet ends
         assign in_word[g*SEG_W +: SEG_W] = {data, bytes, ena, sop, eop, err, ena & ~err};
      end
   endgenerate

   tsp_skid_buffer #(
      .WIDTH (BUF_W)
   ) u_buf (
      .clk       (CLOCK),
      .rst_b     (RST_B),
      .in_valid  (any_enable),
      .in_ready  (buf_in_ready),
      .in_data   (in_word),
      .out_valid (buf_valid),
      .out_ready (take_out),
      .out_data  (buf_word)
   );

   // registered output stage, segments kept in order zero to three
   integer i;
   always @(posedge CLOCK) begin
      if (!RST_B) begin
         SEG_READY          <= 1'b0;
         SEG_OVERFLOW       <= 1'b0;
         OUT_VALID          <= 1'b0;
         OUT_SEG_VALID      <= {NUM_SEG{1'b0}};
         OUT_SEG_START      <= {NUM_SEG{1'b0}};
         OUT_SEG_END        <= {NUM_SEG{1'b0}};
         OUT_SEG_ERROR      <= {NUM_SEG{1'b0}};
         OUT_SEG_BYTE_COUNT <= {NUM_SEG*5{1'b0}};
         OUT_SEG_FCS_ENABLE <= {NUM_SEG{1'b0}};
         OUT_SEG_DATA       <= {NUM_SEG*DATA_W{1'b0}};
      end else begin
         SEG_READY <= buf_in_ready;
         if (any_enable && !buf_in_ready) begin
            SEG_OVERFLOW <= 1'b1;
         end
         if (take_out) begin
            OUT_VALID <= buf_valid;
            for (i = 0; i < NUM_SEG; i = i + 1) begin
               OUT_SEG_FCS_ENABLE[i]      <= buf_valid & buf_word[i*SEG_W];
               OUT_SEG_ERROR[i]           <= buf_valid & buf_word[i*SEG_W+1];
               OUT_SEG_END[i]             <= buf_valid & buf_word[i*SEG_W+2];
               OUT_SEG_START[i]           <= buf_valid & buf_word[i*SEG_W+3];
               OUT_SEG_VALID[i]           <= buf_valid & buf_word[i*SEG_W+4];
               // empty buffer slots are never shown, so no stale word leaks out
               OUT_SEG_BYTE_COUNT[i*5 +: 5] <= buf_valid ? buf_word[i*SEG_W+5 +: 5] : 5'h00;
               OUT_SEG_DATA[i*DATA_W +: DATA_W] <= buf_valid ? buf_word[i*SEG_W+10 +: DATA_W] : {DATA_W{1'b0}};
            end
         end
      end
   end
endmodule // tsp_tx_segment_end

// ===== src/tsp_defines.vh
// constants for the transmit segment end, error and empty-byte block
`ifndef TSP_DEFINES_VH
`define TSP_DEFINES_VH
`define TSP_NUM_SEG        4
`define TSP_DATA_W         128
`define TSP_EMPTY_W        4
`define TSP_BYTES_W        5
`define TSP_SEG_BYTES      5'h10
`define TSP_EMPTY_LOW_MASK 4'h8
`define TSP_ERR_CODE_WORD  128'hFEFE_FEFE_FEFE_FEFE_FEFE_FEFE_FEFE_FEFE
`define TSP_BUF_DEPTH      2
`endif

// ===== src/tsp_skid_buffer.v
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module tsp_skid_buffer #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             rst_b,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:1];
   reg             wr_ptr;
   reg             rd_ptr;
   reg [1:0]       count;
   wire            do_wr;
   wire            do_rd;

   assign in_ready  = (count != 2'd2);
   assign out_valid = (count != 2'd0);
   assign out_data  = mem[rd_ptr];
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;

   always @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
      if (!rst_b) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count  <= 2'd0;
      end else begin
         if (do_wr) begin
            wr_ptr <= ~wr_ptr;
         end
         if (do_rd) begin
            rd_ptr <= ~rd_ptr;
         end
         if (do_wr && !do_rd) begin
            count <= count + 2'd1;
         end else if (do_rd && !do_wr) begin
            count <= count - 2'd1;
         end
      end
   end
endmodule // tsp_skid_buffer

// ===== tb/tsp_tx_segment_end_asserts.sv
// checker on the segment end block outputs
`timescale 1ns/10ps
`include "tsp_defines.vh"
module tsp_tx_segment_end_asserts (
   input wire CLOCK, RST_B, SEG_READY, OUT_VALID, OUT_READY,
   input wire [3:0] SEG_VALID_ENABLE, OUT_SEG_VALID, OUT_SEG_END, OUT_SEG_ERROR, OUT_SEG_FCS_ENABLE,
   input wire [19:0] OUT_SEG_BYTE_COUNT,
   input wire [511:0] OUT_SEG_DATA
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_B);
   sequence take_s; |SEG_VALID_ENABLE && SEG_READY && !OUT_VALID; endsequence
   sequence show_s; ##2 OUT_VALID; endsequence
   word_latency_a: assert property (take_s |-> show_s) else $error("late");
   word_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_SEG_DATA))
      else $error("lost");
   end_gate_a: assert property (!(OUT_SEG_END & ~OUT_SEG_VALID)) else $error("end");
   err_gate_a: assert property (!(OUT_SEG_ERROR & ~OUT_SEG_END)) else $error("err");
   fcs_off_a: assert property (OUT_VALID |-> OUT_SEG_FCS_ENABLE == (OUT_SEG_VALID & ~OUT_SEG_ERROR))
      else $error("fcs");
   err_word_a: assert property (OUT_VALID && OUT_SEG_ERROR[1] |-> OUT_SEG_DATA[255:128] == `TSP_ERR_CODE_WORD)
      else $error("word");
   err_count_a: assert property (OUT_VALID && OUT_SEG_ERROR[1] |-> OUT_SEG_BYTE_COUNT[9:5] inside {5'h08, 5'h10})
      else $error("count");
   mid_count_a: assert property (OUT_VALID && OUT_SEG_VALID[0] && !OUT_SEG_END[0] |-> OUT_SEG_BYTE_COUNT[4:0] == 5'h10)
      else $error("mid");
endmodule // tsp_tx_segment_end_asserts
bind tsp_tx_segment_end tsp_tx_segment_end_asserts i_chk (.CLOCK(CLOCK), .RST_B(RST_B), .SEG_READY(SEG_READY),
   .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .SEG_VALID_ENABLE(SEG_VALID_ENABLE), .OUT_SEG_VALID(OUT_SEG_VALID),
   .OUT_SEG_END(OUT_SEG_END), .OUT_SEG_ERROR(OUT_SEG_ERROR), .OUT_SEG_FCS_ENABLE(OUT_SEG_FCS_ENABLE),
   .OUT_SEG_BYTE_COUNT(OUT_SEG_BYTE_COUNT), .OUT_SEG_DATA(OUT_SEG_DATA));

// ===== tb/tsp_user_tx.sv
// user-side source of segment transfers
`timescale 1ns/10ps
module tsp_user_tx (
   input wire CLOCK,
   output reg [3:0] en, st, eop, err,
   output reg [15:0] cnt,
   output reg [511:0] dat
);
   initial {en, st, eop, err, cnt, dat} = 0;
   task put(input [3:0] e, s, p, r, input [15:0] c, input [511:0] d);
      {en, st, eop, err, cnt, dat} = {e, s, p, r, c, d};
      @(posedge CLOCK) #1;
   endtask
   task idle; // unselected lines show inverted values
      en = 0;
      {st, eop, err, cnt, dat} = ~{st, eop, err, cnt, dat};
   endtask
endmodule // tsp_user_tx

// ===== tb/tsp_tx_segment_end_tb_top.sv
// testbench for the segment end block
`timescale 1ns/10ps
`include "tsp_defines.vh"
module tsp_tx_segment_end_tb_top;
   reg CLOCK = 0, RST_B = 0, OUT_READY = 0;
   wire [3:0] en, st, eop, err, ov, os, oe, orr, of;
   wire [15:0] cnt;
   wire [19:0] obc;
   wire [511:0] dat, od;
   wire ovl, ovf, rdy;
   integer miscompares = 0, n_tests = 0, i, k;
   reg [511:0] w = {{16{8'h33}}, {16{8'h22}}, {16{8'h11}}, {16{8'h00}}}, m;
   always #5 CLOCK = ~CLOCK;
   tsp_user_tx i_usr (.CLOCK(CLOCK), .en(en), .st(st), .eop(eop), .err(err), .cnt(cnt), .dat(dat));
   tsp_tx_segment_end i_dut (.CLOCK(CLOCK), .RST_B(RST_B), .SEG_VALID_ENABLE(en), .SEG_START_MARKER(st),
      .SEG_END_MARKER(eop), .SEG_BAD_PACKET_FLAG(err), .SEG_EMPTY_BYTE_COUNT(cnt), .SEG_PAYLOAD_BUS(dat), .SEG_READY(rdy),
      .SEG_OVERFLOW(ovf), .OUT_VALID(ovl), .OUT_READY(OUT_READY), .OUT_SEG_VALID(ov), .OUT_SEG_START(os),
      .OUT_SEG_END(oe), .OUT_SEG_ERROR(orr), .OUT_SEG_BYTE_COUNT(obc), .OUT_SEG_FCS_ENABLE(of), .OUT_SEG_DATA(od));
   task check(input [511:0] seen, exp);
      n_tests = n_tests + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task take(input [39:0] f, input [511:0] d); // wait for a word, judge it, accept it
      for (i = 0; i < 9 && ovl !== 1'b1; i = i + 1) @(posedge CLOCK) #1;
      check({of, ov, os, oe, orr, obc}, f);
      check(od & m, d & m);
      OUT_READY = 1;
      @(posedge CLOCK) #1;
      OUT_READY = 0;
   endtask
   task t_plain; // seg3 closes a good packet, counts on other segments ignored
      m = '1;
      i_usr.put(4'hF, 4'h1, 4'h8, 4'h0, 16'h5777, w);
      i_usr.idle;
      take({4'hF, 4'hF, 4'h1, 4'h8, 4'h0, 5'h0B, 5'h10, 5'h10, 5'h10}, w);
      $display("plain end");
   endtask
   task t_err_stall; // bad packet ends on seg1, error on seg2 without end ignored, next word waits
      m = {128'h0, {384{1'b1}}};
      i_usr.put(4'h7, 4'h5, 4'hA, 4'hE, 16'hFFFF, ~w);
      i_usr.put(4'h1, 4'h0, 4'h1, 4'h0, 16'h0003, w);
      i_usr.idle;
      repeat (4) @(posedge CLOCK) #1;
      check({rdy, ovf}, 2'b10);
      take({4'h5, 4'h7, 4'h5, 4'h2, 4'h2, 5'h00, 5'h10, 5'h08, 5'h10},
         {~w[511:256], `TSP_ERR_CODE_WORD, ~w[127:0]});
      m = {384'h0, {128{1'b1}}};
      take({4'h1, 4'h1, 4'h0, 4'h1, 4'h0, 15'h0, 5'h0D}, w);
      $display("error stall end");
   endtask
   task t_overflow; // stalled output: buffer fills, fourth word dropped, reset clears the flag
      m = {384'h0, {128{1'b1}}};
      for (k = 1; k <= 4; k = k + 1) i_usr.put(4'h1, 4'h0, 4'h0, 4'h0, 16'h0, k);
      i_usr.idle;
      check({rdy, ovf}, 2'b01);
      for (k = 1; k <= 3; k = k + 1) take({4'h1, 4'h1, 4'h0, 4'h0, 4'h0, 15'h0, 5'h10}, k);
      check(ovl, 1'b0);
      RST_B = 0;
      @(posedge CLOCK) #1;
      check({rdy, ovf, ovl}, 3'b000);
      RST_B = 1;
      @(posedge CLOCK) #1;
      check({rdy, ovf, ovl}, 3'b100);
      $display("overflow end");
   endtask
   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge CLOCK);
      #1 RST_B = 1;
      @(posedge CLOCK) #1;
      t_plain;
      t_err_stall;
      t_overflow;
      wrap_up;
   end
   initial begin // tests need under 100 cycles
      #5000;
      miscompares = miscompares + 1;
      wrap_up;
   end
endmodule // tsp_tx_segment_end_tb_top
